// ---- src/seep_pkg.sv ----
// Shared constants and types for the serial memory command port.
package seep_pkg;

  // Clock and self-timed programming figures.
  localparam int CLK_NS = 40;
  localparam int T_EW_NS = 10000000;
  // A longest time rounds down to whole clock cycles.
  localparam int PROG_CYC = T_EW_NS / CLK_NS;
  localparam int TMR_W = 18;

  // Array and frame geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int WORDS = 256;
  localparam int FIFO_DEPTH = 32;
  localparam logic [4:0] CNT_OPC_LAST = 5'h01;
  localparam logic [4:0] CNT_ADDR_LAST = 5'h07;
  localparam logic [4:0] CNT_DATA_LAST = 5'h0f;
  localparam logic [4:0] CNT_READ_END = 5'h10;

  // Opcodes and the extended codes carried in the two top address bits.
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] EXT_PROG_EN = 2'h3;
  localparam logic [1:0] EXT_PROG_DIS = 2'h0;
  localparam logic [1:0] EXT_WRITE_ALL = 2'h1;
  localparam logic [1:0] EXT_ERASE_ALL = 2'h2;

  // Value of an erased word.
  localparam logic [15:0] ERASED_WORD = 16'hffff;

  // Serial frame states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OPC,
    ST_ADDR,
    ST_DATA,
    ST_READ,
    ST_ARMED,
    ST_DONE
  } seep_state_e;

  // One queued programming command.
  typedef struct packed {
    logic [1:0] op;
    logic [7:0] addr;
    logic [15:0] data;
  } seep_cmd_s;

  localparam int CMD_W = $bits(seep_cmd_s);

  // Whole state of the command port.
  typedef struct packed {
    logic cs_m;
    logic cs_s;
    logic cs_p;
    logic sk_m;
    logic sk_s;
    logic sk_p;
    logic di_m;
    logic di_s;
    seep_state_e st;
    logic [4:0] cnt;
    seep_cmd_s cmd;
    logic [15:0] sh;
    logic en;
    logic stat;
    logic pend;
    logic dout;
    logic oe_n;
    logic act;
    logic [17:0] tmr;
    seep_cmd_s run;
    logic commit;
  } seep_port_s;

endpackage

// ---- src/seep_fifo.sv ----
// Flop-based FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module seep_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_i,
  // Filling side.
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Draining side.
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  logic [DEPTH-1:0][WIDTH-1:0] mem_q;
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rp_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop)
      begin
        rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage needs no reset; empty entries are never presented.
  always_ff @(posedge mclk_i)
  begin
    if (push)
    begin
      mem_q[wp_q] <= in_data_i;
    end
  end

endmodule

// ---- src/seep_port.sv ----
// Serial command port and word array of the small serial memory.
`timescale 1ns/1ps
// Contract
// - Frame is start one, opcode, eight address bits.
// - Opcodes read, write and erase one word.
// - Opcode zero uses top address bits.
// - Small variant ignores top address bit.
// - Array holds 128 or 256 sixteen-bit words.
// - Read bits leave on serial clock rises.
// - Read sends dummy zero then sixteen bits.
// - Output floats except read or status.
// - Programming starts disabled after power-up.
// - Enable holds until disable or power loss.
// - Reads work whatever the enable state.
// - Select fall after data starts word write.
// - Raised select during cycle shows status.
// - Select fall after address starts word erase.
// - Write-all erases then programs every word.
// - Erase-all clears every cell at once.
module seep_port #(
  parameter bit WIDE_ARRAY = 1'b1,
  parameter logic [17:0] PROG_CYCLES = 18'(seep_pkg::PROG_CYC)
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_i,
  // Serial pins from the host.
  input wire logic select_i,
  input wire logic serial_clock_input_i,
  input wire logic serial_in_i,
  // Serial data out, a three-state pin.
  output logic serial_out_o,
  output logic serial_out_oe_n_o,
  // Self-timed cycle in progress.
  output logic busy_o
);

  seep_pkg::seep_port_s q;
  seep_pkg::seep_port_s d;
  logic [seep_pkg::WORDS-1:0][15:0] mem_q;
  logic sk_rise;
  logic cs_rise;
  logic busy;
  logic [7:0] addr_full;
  logic [7:0] addr_fin;
  logic f_in_ready;
  logic f_out_valid;
  logic f_pop;
  seep_pkg::seep_cmd_s f_out_data;
  logic program_enable_cmd_hit;
  logic program_disable_cmd_hit;

  // Edges come from the second and third stages only.
  assign sk_rise = q.sk_s & ~q.sk_p;
  assign cs_rise = q.cs_s & ~q.cs_p;
  // A command waiting to queue, queued or running all count as busy.
  assign busy = q.pend | f_out_valid | q.act;
  assign busy_o = busy;
  assign serial_out_o = q.dout;
  assign serial_out_oe_n_o = q.oe_n;
  assign f_pop = ~q.act;

  // Full address as it stands once the last address bit is shifted in.
  assign addr_full = {q.cmd.addr[6:0], q.di_s};
  // The small variant drops the top address bit.
  assign addr_fin = WIDE_ARRAY ? addr_full : {1'b0, addr_full[6:0]};
  assign program_enable_cmd_hit = sk_rise & (q.st == seep_pkg::ST_ADDR) & (q.cnt == seep_pkg::CNT_ADDR_LAST)
                    & (q.cmd.op == seep_pkg::OP_EXT) & (addr_full[7:6] == seep_pkg::EXT_PROG_EN);
  assign program_disable_cmd_hit = sk_rise & (q.st == seep_pkg::ST_ADDR) & (q.cnt == seep_pkg::CNT_ADDR_LAST)
                    & (q.cmd.op == seep_pkg::OP_EXT) & (addr_full[7:6] == seep_pkg::EXT_PROG_DIS);

  // Launched commands pass through here; no frame starts while busy, so it holds one at most.
  seep_fifo #(
    .WIDTH(seep_pkg::CMD_W),
    .DEPTH(seep_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .in_valid_i(q.pend),
    .in_ready_o(f_in_ready),
    .in_data_i(q.cmd),
    .out_valid_o(f_out_valid),
    .out_ready_i(f_pop),
    .out_data_o(f_out_data)
  );

  // Next-state logic for the whole port.
  always_comb
  begin
    d = q;
    d.commit = 1'b0;
    d.cs_m = select_i;
    d.cs_s = q.cs_m;
    d.cs_p = q.cs_s;
    d.sk_m = serial_clock_input_i;
    d.sk_s = q.sk_m;
    d.sk_p = q.sk_s;
    d.di_m = serial_in_i;
    d.di_s = q.di_m;
    if (!q.cs_s)
    begin
      // Select low ends any frame and floats the output.
      d.st = seep_pkg::ST_IDLE;
      d.oe_n = 1'b1;
      d.stat = 1'b0;
      // The fall of select launches an armed command, if enabled.
      if (q.st == seep_pkg::ST_ARMED && q.en)
      begin
        d.pend = 1'b1;
      end
    end
    else
    begin
      // Raising select while busy shows ready/busy on the output.
      if (cs_rise && busy)
      begin
        d.stat = 1'b1;
      end
      if (q.stat)
      begin
        d.oe_n = 1'b0;
        d.dout = ~busy; // Low while busy, high once done.
      end
      if (sk_rise)
      begin
        unique case (q.st)
          seep_pkg::ST_IDLE:
          begin
            // A start bit of one opens a frame; ignored while busy.
            if (q.di_s && !busy)
            begin
              d.st = seep_pkg::ST_OPC;
              d.cnt = '0;
              d.stat = 1'b0;
              d.oe_n = 1'b1;
            end
          end
          seep_pkg::ST_OPC:
          begin
            d.cmd.op = {q.cmd.op[0], q.di_s};
            d.cnt = q.cnt + 5'h01;
            if (q.cnt == seep_pkg::CNT_OPC_LAST)
            begin
              d.st = seep_pkg::ST_ADDR;
              d.cnt = '0;
            end
          end
          seep_pkg::ST_ADDR:
          begin
            d.cmd.addr = addr_full; // Most significant bit first.
            d.cnt = q.cnt + 5'h01;
            if (q.cnt == seep_pkg::CNT_ADDR_LAST)
            begin
              d.cmd.addr = addr_fin;
              d.cnt = '0;
              unique case (q.cmd.op)
                seep_pkg::OP_READ:
                begin
                  // Reads ignore the enable state; dummy zero goes out now.
                  d.st = seep_pkg::ST_READ;
                  d.sh = mem_q[addr_fin];
                  d.oe_n = 1'b0;
                  d.dout = 1'b0;
                end
                seep_pkg::OP_WRITE:
                begin
                  d.st = seep_pkg::ST_DATA;
                end
                seep_pkg::OP_ERASE:
                begin
                  d.st = seep_pkg::ST_ARMED;
                end
                seep_pkg::OP_EXT:
                begin
                  // Only the two top address bits pick the operation.
                  unique case (addr_full[7:6])
                    seep_pkg::EXT_PROG_EN:
                    begin
                      d.en = 1'b1;
                      d.st = seep_pkg::ST_DONE;
                    end
                    seep_pkg::EXT_PROG_DIS:
                    begin
                      d.en = 1'b0; // Only this and reset clear the enable.
                      d.st = seep_pkg::ST_DONE;
                    end
                    seep_pkg::EXT_WRITE_ALL:
                    begin
                      d.st = seep_pkg::ST_DATA;
                    end
                    seep_pkg::EXT_ERASE_ALL:
                    begin
                      d.st = seep_pkg::ST_ARMED;
                      // The small variant loses the code's top bit, so carry erased data.
                      d.cmd.data = seep_pkg::ERASED_WORD;
                    end
                  endcase
                end
              endcase
            end
          end
          seep_pkg::ST_DATA:
          begin
            d.cmd.data = {q.cmd.data[14:0], q.di_s};
            d.cnt = q.cnt + 5'h01;
            if (q.cnt == seep_pkg::CNT_DATA_LAST)
            begin
              d.st = seep_pkg::ST_ARMED;
            end
          end
          seep_pkg::ST_READ:
          begin
            // Each rise presents the next bit, then the pin floats.
            if (q.cnt == seep_pkg::CNT_READ_END)
            begin
              d.st = seep_pkg::ST_DONE;
              d.oe_n = 1'b1;
            end
            else
            begin
              d.dout = q.sh[15];
              d.sh = {q.sh[14:0], 1'b0};
              d.oe_n = 1'b0;
              d.cnt = q.cnt + 5'h01;
            end
          end
          seep_pkg::ST_ARMED,
          seep_pkg::ST_DONE:
          begin
            d.st = q.st;
          end
        endcase
      end
    end
    // A launched command moves into the queue when there is room.
    if (q.pend && f_in_ready)
    begin
      d.pend = 1'b0;
    end
    // The self-timed engine takes one command and commits at timeout.
    if (!q.act && f_out_valid)
    begin
      d.act = 1'b1;
      d.run = f_out_data;
      d.tmr = PROG_CYCLES - 18'h00001;
    end
    else if (q.act)
    begin
      if (q.tmr == '0)
      begin
        d.act = 1'b0;
        d.commit = 1'b1;
      end
      else
      begin
        d.tmr = q.tmr - 18'h00001;
      end
    end
  end

  // Power-up state: programming disabled, output floating.
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.st <= seep_pkg::ST_IDLE;
      q.oe_n <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // One word per entry; the whole-array commands hit every entry at once.
  // Erase-before-program leaves the new data, so one write does both.
  for (genvar i = 0; i < seep_pkg::WORDS; i++)
  begin : g_word
    logic hit;
    logic erase;
    assign hit = q.commit & ((q.run.op == seep_pkg::OP_EXT) || (q.run.addr == 8'(i)));
    assign erase = (q.run.op == seep_pkg::OP_ERASE) ||
                   ((q.run.op == seep_pkg::OP_EXT) &&
                    (q.run.addr[7:6] == seep_pkg::EXT_ERASE_ALL));
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        mem_q[i] <= seep_pkg::ERASED_WORD;
      end
      else if (hit)
      begin
        mem_q[i] <= erase ? seep_pkg::ERASED_WORD : q.run.data;
      end
    end
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_addr_done;
    sk_rise && (q.st == seep_pkg::ST_ADDR) && (q.cnt == seep_pkg::CNT_ADDR_LAST);
  endsequence

  sequence s_read_start;
    $rose(q.st == seep_pkg::ST_READ);
  endsequence

  chk_select_low_float: assert property (!q.cs_s |=> q.oe_n)
    else $error("Output driven after select went low.");
  chk_dummy_bit_zero: assert property (s_read_start |-> (!q.dout && !q.oe_n))
    else $error("Read did not start with a driven zero.");
  chk_read_any_enable: assert property (
    s_addr_done ##0 (q.cmd.op == seep_pkg::OP_READ) |=> (q.st == seep_pkg::ST_READ))
    else $error("Read not started after its address.");
  chk_queue_needs_en: assert property ($rose(q.pend) |-> $past(q.en))
    else $error("Programming command queued while disabled.");
  chk_enable_cause: assert property ($rose(q.en) |-> $past(program_enable_cmd_hit))
    else $error("Enable set without the enable instruction.");
  chk_disable_cause: assert property ($fell(q.en) |-> $past(program_disable_cmd_hit))
    else $error("Enable cleared without the disable instruction.");
  chk_status_level: assert property (
    (q.stat && q.cs_s && !(sk_rise && q.di_s && !busy)) |=> (!q.oe_n && q.dout == !$past(busy)))
    else $error("Status level does not follow busy.");
  chk_small_addr: assert property (($rose(q.pend) && !WIDE_ARRAY) |-> !q.cmd.addr[7])
    else $error("Top address bit kept on small variant.");
  chk_cycle_min_len: assert property ($rose(q.act) |-> q.act [*8])
    else $error("Self-timed cycle ended too early.");
  chk_read_bit_edge: assert property (
    (q.st == seep_pkg::ST_READ && $changed(q.sh)) |-> $past(sk_rise))
    else $error("Read bit moved without a clock rise.");

endmodule

// ---- tb/seep_host.sv ----
// Host-side model that drives the serial pins of the memory port.
`timescale 1ns/1ps
module seep_host (
  // Clock that paces the pins.
  input wire logic mclk_i,
  // Serial pins.
  output logic select_o,
  output logic sck_o,
  output logic sdi_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_n_i
);
  // Nothing pulls the data-out wire, so a released pin reads as floating.
  wire logic line = sdo_oe_n_i ? 1'bz : sdo_i; // Kept apart from data-in, no dummy clash.

  // Pins rest with clock and select low between frames.
  initial
  begin
    select_o = 1'b0;
    sck_o = 1'b0;
    sdi_o = 1'b0;
  end

  // Wait some system clocks, then step off the edge by the fixed small delay.
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  // Sends n bits MSB first, one clock rise each, then takes nrd read bits.
  task automatic frame(input logic [26:0] bits, input int n, input int nrd,
                       output logic [16:0] rd);
    rd = 17'h00000;
    select_o = 1'b1;
    tick(4);
    for (int i = n - 1; i >= 0; i--)
    begin
      sdi_o = bits[i];
      tick(4);
      sck_o = 1'b1;
      tick(4);
      sck_o = 1'b0;
    end
    // A read bit is taken just before the rise that replaces it.
    for (int k = nrd - 1; k >= 0; k--)
    begin
      tick(4);
      rd[k] = line;
      if (k > 0)
      begin
        sck_o = 1'b1;
        tick(4);
        sck_o = 1'b0;
      end
    end
    select_o = 1'b0;
    sdi_o = ~sdi_o;
    tick(8);
  endtask

  // Raises select during a timed cycle, samples busy, then ready.
  task automatic status(output logic busy_seen, output logic ready_seen);
    select_o = 1'b1;
    tick(8);
    busy_seen = line;
    tick(64);
    ready_seen = line;
    select_o = 1'b0;
    tick(8);
  endtask
endmodule

// ---- tb/seep_port_test.sv ----
// Self-checking bench for the serial memory command port.
`timescale 1ns/1ps
module seep_port_test;
  logic mclk_i;
  logic rst_i;
  logic select;
  logic sck;
  logic sdi;
  logic sdo;
  logic sdo_oe_n;
  logic busy;
  int n_errors;
  int checked;
  logic [31:0] seed;
  logic [15:0] mem [256];
  bit en;
  logic [16:0] rd;
  logic [7:0] a;
  logic [15:0] d;

  seep_port #(.WIDE_ARRAY(1'b1), .PROG_CYCLES(18'h00020)) i_seep_port (
    .mclk_i(mclk_i), .rst_i(rst_i), .select_i(select), .serial_clock_input_i(sck),
    .serial_in_i(sdi), .serial_out_o(sdo), .serial_out_oe_n_o(sdo_oe_n), .busy_o(busy));

  seep_host i_seep_host (.mclk_i(mclk_i), .select_o(select), .sck_o(sck), .sdi_o(sdi),
    .sdo_i(sdo), .sdo_oe_n_i(sdo_oe_n));

  // Fixed-seed xorshift keeps every run the same.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Prints the verdict and stops.
  task automatic end_sim();
    if (n_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Waits a bounded time for the timed cycle to end.
  task automatic wait_idle();
    for (int i = 0; i < 400 && busy !== 1'b0; i++)
      i_seep_host.tick(1);
    chk({16'h0000, busy}, 17'h00000);
  endtask

  // Reads a word and compares dummy bit plus data with the model.
  task automatic rd_chk(input logic [7:0] ra);
    i_seep_host.frame({16'h0000, 1'b1, seep_pkg::OP_READ, ra}, 11, 17, rd);
    chk(rd, {1'b0, mem[ra]});
    chk({16'h0000, sdo_oe_n}, 17'h00001);
  endtask

  // Issues one command, optionally polls status, and updates the model.
  task automatic cmd(input logic [1:0] op, input logic [7:0] ca, input logic [15:0] cd,
                     input bit st);
    logic b0;
    logic b1;
    bit ext;
    ext = (op == seep_pkg::OP_EXT);
    if (op == seep_pkg::OP_WRITE || (ext && ca[7:6] == seep_pkg::EXT_WRITE_ALL))
      i_seep_host.frame({1'b1, op, ca, cd}, 27, 0, rd);
    else
      i_seep_host.frame({16'h0000, 1'b1, op, ca}, 11, 0, rd);
    if (st)
    begin
      i_seep_host.status(b0, b1);
      chk({16'h0000, b0}, 17'h00000);
      chk({16'h0000, b1}, 17'h00001);
    end
    if (ext && ca[7:6] == seep_pkg::EXT_PROG_EN)
      en = 1'b1;
    if (ext && ca[7:6] == seep_pkg::EXT_PROG_DIS)
      en = 1'b0;
    for (int w = 0; w < 256; w++)
    begin
      if (en && op == seep_pkg::OP_WRITE && w == ca)
        mem[w] = cd;
      if (en && op == seep_pkg::OP_ERASE && w == ca)
        mem[w] = 16'hffff;
      if (en && ext && ca[7:6] == seep_pkg::EXT_WRITE_ALL)
        mem[w] = cd;
      if (en && ext && ca[7:6] == seep_pkg::EXT_ERASE_ALL)
        mem[w] = 16'hffff;
    end
    wait_idle();
  endtask

  // Clock at 25 MHz.
  initial
  begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  // A hang counts as a failure; the span is well above the run's length.
  initial
  begin
    repeat (40000) @(posedge mclk_i);
    n_errors++;
    end_sim();
  end

  // Main sequence.
  initial
  begin
    n_errors = 0;
    checked = 0;
    seed = 32'h00000da5;
    en = 1'b0;
    for (int w = 0; w < 256; w++)
      mem[w] = 16'hffff;
    rst_i = 1'b1;
    repeat (5) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    repeat (4) @(posedge mclk_i);
    #1;
    a = 8'(rnd());
    d = 16'(rnd());
    rd_chk(a);
    cmd(seep_pkg::OP_WRITE, a, d, 1'b0);
    rd_chk(a);
    cmd(seep_pkg::OP_EXT, {seep_pkg::EXT_PROG_EN, 6'h15}, 16'h0000, 1'b0);
    // Words in both halves of the array, the first with status polling.
    for (int i = 0; i < 6; i++)
    begin
      a = {i[0], 7'(rnd())};
      d = 16'(rnd());
      cmd(seep_pkg::OP_WRITE, a, d, i == 0);
      rd_chk(a);
    end
    cmd(seep_pkg::OP_ERASE, a, 16'h0000, 1'b1);
    rd_chk(a);
    cmd(seep_pkg::OP_EXT, {seep_pkg::EXT_WRITE_ALL, 6'h2a}, 16'(rnd()), 1'b1);
    rd_chk(8'(rnd()));
    rd_chk(8'(rnd()));
    cmd(seep_pkg::OP_EXT, {seep_pkg::EXT_ERASE_ALL, 6'h01}, 16'h0000, 1'b1);
    rd_chk(8'(rnd()));
    cmd(seep_pkg::OP_WRITE, a, 16'(rnd()), 1'b0);
    cmd(seep_pkg::OP_EXT, {seep_pkg::EXT_PROG_DIS, 6'h3f}, 16'h0000, 1'b0);
    cmd(seep_pkg::OP_WRITE, a, 16'(rnd()), 1'b0);
    cmd(seep_pkg::OP_EXT, {seep_pkg::EXT_ERASE_ALL, 6'h00}, 16'h0000, 1'b0);
    rd_chk(a);
    end_sim();
  end
endmodule
